/* i2c_switch.sv */
// four-channel i2c bus switch: target on the upstream pair, control byte, alert merge
// assumes all pins arrive asynchronously; the link fabric runs on i_link_clk
`timescale 1ns/100ps
`include "i2c_switch_consts.svh"

// Function
// - upstream pair reaches any one or any mix of four channels per control.
// - each of four channels has one downstream pair fed from the upstream pair.
// - four alert inputs, one per downstream channel.
// - alert output is the AND of the four alert inputs.
// - reset input low restarts the bus machine and deselects every channel.
// - power-on reset does the same as the external reset.
// - variants differ only in target address, a module parameter.
module i2c_switch #(
   parameter logic [6:0] TARGET_ADDR = 7'h2a, // arbitrary value, set per variant
   parameter int CH = `SW_CHANNELS,
   parameter int POR_CYCLES = `SW_POR_CYCLES
) (
   // clocks and reset
   input wire logic i_clk,
   input wire logic i_link_clk,
   input wire logic i_rst_n,
   // upstream pair
   input wire i2c_switch_pkg::i2c_pair_type i_up,
   output i2c_switch_pkg::i2c_pair_type o_up_oe,
   // downstream pairs
   input wire logic [CH-1:0] i_downstream_clock_line,
   input wire logic [CH-1:0] i_downstream_data_line,
   output logic [CH-1:0] o_downstream_clock_line_oe,
   output logic [CH-1:0] o_downstream_data_line_oe,
   // alerts
   input wire logic [CH-1:0] i_channel_alert_in_n,
   output logic o_alert_n,
   // status
   output logic [CH-1:0] o_channel_sel
);
   import i2c_switch_pkg::*;

   tgt_state_type state, next_state;
   i2c_pair_type up_s1, up_s2, up_d;
   i2c_pair_type dn_low_s1, dn_low_s2, dn_low;
   i2c_pair_type fab_low;
   logic [CH-1:0] alert_s1, alert_s2;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic rw, nack, drive;
   logic [CH-1:0] sel_word;
   logic sel_req, ack_s1, ack_s2;
   logic [$clog2(POR_CYCLES+1)-1:0] por_cnt;
   wire sel_ack;

   // ==========================================
   // bus conditions from the synchronised pair
   wire start_seen = up_s2.scl && up_d.scl && up_d.sda && !up_s2.sda;
   wire stop_seen = up_s2.scl && up_d.scl && !up_d.sda && up_s2.sda;
   wire scl_rise = up_s2.scl && !up_d.scl;
   wire scl_fall = !up_s2.scl && up_d.scl;
   wire byte_done = bit_cnt == `SW_BYTE_BITS;
   wire addr_hit = shift[7:1] == TARGET_ADDR;
   wire por_busy = por_cnt != '0;
   wire hs_idle = ack_s2 == sel_req;
   wire [CH-1:0] next_sel = o_channel_sel;
   wire next_alert_n = &alert_s2;

   // ==========================================
   // target state machine: next state
   always_comb begin
      next_state = state;
      case (state)
         st_idle: next_state = st_idle;
         st_addr: if (scl_fall && byte_done) next_state = addr_hit ? st_ack : st_idle;
         st_ack: if (scl_fall) next_state = rw ? st_rd : st_wr;
         st_wr: if (scl_fall && byte_done) next_state = st_ack;
         st_rd: if (scl_fall && byte_done) next_state = st_rd_ack;
         st_rd_ack: if (scl_fall) next_state = nack ? st_idle : st_rd;
         default: next_state = st_idle;
      endcase
      if (start_seen) next_state = st_addr;
      if (stop_seen || por_busy) next_state = st_idle;
   end

   // ==========================================
   // pin synchronisers and power-on hold
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up_s1 <= 2'h3;
         up_s2 <= 2'h3;
         up_d <= 2'h3;
         dn_low_s1 <= 2'h0;
         dn_low_s2 <= 2'h0;
         dn_low <= 2'h0;
         alert_s1 <= '1;
         alert_s2 <= '1;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         por_cnt <= ($clog2(POR_CYCLES+1))'(POR_CYCLES);
      end else begin
         up_s1 <= i_up;
         up_s2 <= up_s1;
         up_d <= up_s2;
         dn_low_s1 <= fab_low;
         dn_low_s2 <= dn_low_s1;
         dn_low <= dn_low_s2;
         alert_s1 <= i_channel_alert_in_n;
         alert_s2 <= alert_s1;
         ack_s1 <= sel_ack;
         ack_s2 <= ack_s1;
         if (por_busy) por_cnt <= por_cnt - 1'b1;
      end
   end

   // ==========================================
   // bit shifting, acknowledge and read-back drive
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= st_idle;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         rw <= 1'b0;
         nack <= 1'b0;
         drive <= 1'b0;
      end else begin
         state <= next_state;
         if (start_seen || stop_seen || por_busy) begin
            bit_cnt <= 4'h0;
            drive <= 1'b0;
         end else if (scl_rise && (state == st_addr || state == st_wr)) begin
            shift <= {shift[6:0], up_s2.sda};
            bit_cnt <= bit_cnt + 4'h1;
         end else if (scl_rise && state == st_rd) begin
            bit_cnt <= bit_cnt + 4'h1;
         end else if (scl_rise && state == st_rd_ack) begin
            nack <= up_s2.sda;
         end else if (scl_fall) begin
            case (state)
               st_addr: begin
                  rw <= shift[0];
                  drive <= byte_done && addr_hit;
               end
               st_wr: drive <= byte_done;
               st_ack, st_rd_ack: begin
                  bit_cnt <= 4'h0;
                  // read data: control byte, upper bits zero
                  shift <= {{(8-CH){1'b0}}, o_channel_sel};
                  drive <= rw && !(state == st_rd_ack && nack) && !o_channel_sel[CH-1] && (CH == 8);
                  if (rw && (CH < 8)) drive <= !(state == st_rd_ack && nack);
               end
               st_rd: begin
                  shift <= {shift[6:0], 1'b0};
                  drive <= !byte_done && !shift[6];
               end
               default: drive <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================
   // control register and its handshake into the link domain
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_channel_sel <= `SW_CTRL_RESET;
         sel_word <= `SW_CTRL_RESET;
         sel_req <= 1'b0;
      end else begin
         if (por_busy) o_channel_sel <= `SW_CTRL_RESET;
         else if (state == st_wr && scl_fall && byte_done) o_channel_sel <= shift[CH-1:0];
         // word stays put until the link side acknowledges
         if (hs_idle && (sel_word != next_sel)) begin
            sel_word <= next_sel;
            sel_req <= ~sel_req;
         end
      end
   end

   // ==========================================
   // registered outputs: upstream drive and merged alert
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_up_oe <= 2'h0;
         o_alert_n <= 1'b1;
      end else begin
         o_up_oe <= '{scl: dn_low.scl, sda: drive || dn_low.sda};
         o_alert_n <= next_alert_n;
      end
   end

   // ==========================================
   // link-side fabric

   switch_fabric #(
      .CH(CH)
   ) u_fabric (
      .i_link_clk(i_link_clk),
      .i_rst_n(i_rst_n),
      .i_sel_word(sel_word),
      .i_sel_req(sel_req),
      .o_sel_ack(sel_ack),
      .i_up(i_up),
      .i_dn_scl(i_downstream_clock_line),
      .i_dn_sda(i_downstream_data_line),
      .o_dn_scl_oe(o_downstream_clock_line_oe),
      .o_dn_sda_oe(o_downstream_data_line_oe),
      .o_dn_low(fab_low)
   );

   // ==========================================
   // checks on the core clock
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   AST_ALERT_AND: assert property (##1 (o_alert_n == $past(&alert_s2)))
      else $error("alert output is not the and of the alert inputs");
   AST_ALERT_LOW: assert property ((alert_s2 != '1) |=> !o_alert_n)
      else $error("one low alert did not pull the output low");
   AST_POR_DESELECT: assert property (por_busy |-> (o_channel_sel == '0) && (state == st_idle))
      else $error("channels selected during power-on hold");
   AST_WRITE_SETS: assert property ((state == st_wr && scl_fall && byte_done && !start_seen && !stop_seen)
      |=> (o_channel_sel == $past(shift[CH-1:0])))
      else $error("control byte not stored");
   AST_SEL_STABLE: assert property (!(state == st_wr && scl_fall) && !por_busy |=> $stable(o_channel_sel))
      else $error("control changed without a write");
   AST_ADDR_MISS: assert property ((state == st_addr && scl_fall && byte_done && !addr_hit && !start_seen)
      |=> (state == st_idle) && !drive)
      else $error("foreign address acknowledged");
   AST_ADDR_ACK: assert property ((state == st_addr && scl_fall && byte_done && addr_hit && !start_seen
      && !stop_seen && !por_busy) |=> drive ##1 o_up_oe.sda)
      else $error("own address not acknowledged");
   AST_STOP_IDLE: assert property (stop_seen |=> (state == st_idle))
      else $error("stop did not return the machine to idle");
   AST_HS_WORD: assert property (!hs_idle |=> $stable(sel_word))
      else $error("selection word changed mid handshake");
   COV_WRITE: cover property (state == st_wr && scl_fall && byte_done);
   COV_READ: cover property (state == st_rd_ack && scl_fall);
   COV_ALERT: cover property (!o_alert_n);

endmodule

/* i2c_switch_consts.svh */
// constants for the four-channel i2c bus switch: timing counts, widths, reset values
// assumes inclusion by every design file that needs them; definitions only
`ifndef I2C_SWITCH_CONSTS_SVH
`define I2C_SWITCH_CONSTS_SVH

// ==========================================
// widths and reset values
`define SW_CHANNELS 4
`define SW_CTRL_RESET 4'h0
`define SW_BYTE_BITS 4'h8

// ==========================================
// power-on hold, in ns, and its cycle count at 250 MHz (4 ns)
`define SW_POR_HOLD_NS 200
`define SW_CLK_PERIOD_NS 4
`define SW_POR_CYCLES ((`SW_POR_HOLD_NS + `SW_CLK_PERIOD_NS - 1) / `SW_CLK_PERIOD_NS)

`endif

/* i2c_switch_pkg.sv */
// types shared by the switch core and its link-side fabric
// assumes i2c_switch_consts.svh for numeric constants
package i2c_switch_pkg;

   // one open-drain clock/data pair, as levels or as enables
   typedef struct packed {
      logic scl;
      logic sda;
   } i2c_pair_type;

   // target state machine
   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_ack,
      st_wr,
      st_rd,
      st_rd_ack
   } tgt_state_type;

endpackage

/* switch_fabric.sv */
// link-side fabric of the bus switch: repeats the upstream pair onto selected channels
// assumes i_link_clk is the link's free-running clock and all pins are asynchronous to it
`timescale 1ns/100ps
`include "i2c_switch_consts.svh"

module switch_fabric #(
   parameter int CH = `SW_CHANNELS
) (
   // clock and reset
   input wire logic i_link_clk,
   input wire logic i_rst_n,
   // selection word handshake from the core domain
   input wire logic [CH-1:0] i_sel_word,
   input wire logic i_sel_req,
   output logic o_sel_ack,
   // upstream pair levels (pins)
   input wire i2c_switch_pkg::i2c_pair_type i_up,
   // downstream pins
   input wire logic [CH-1:0] i_dn_scl,
   input wire logic [CH-1:0] i_dn_sda,
   output logic [CH-1:0] o_dn_scl_oe,
   output logic [CH-1:0] o_dn_sda_oe,
   // a selected channel pulls its line low on its own
   output i2c_switch_pkg::i2c_pair_type o_dn_low
);
   import i2c_switch_pkg::*;

   logic [1:0] rst_sync;
   logic req_s1, req_s2;
   logic [CH-1:0] sel;
   i2c_pair_type up_s1, up_s2;
   logic [CH-1:0] scl_s1, scl_s2, sda_s1, sda_s2;
   logic [CH-1:0] scl_own1, scl_own2, sda_own1, sda_own2;
   logic [CH-1:0] scl_src, sda_src;
   wire link_rst_n = rst_sync[1];
   wire take_word = req_s2 != o_sel_ack;
   // own drive still visible through the pin synchroniser is not a far-side low
   wire [CH-1:0] scl_own = o_dn_scl_oe | scl_own1 | scl_own2;
   wire [CH-1:0] sda_own = o_dn_sda_oe | sda_own1 | sda_own2;
   // a selected channel held low by its far side, not by us
   wire [CH-1:0] scl_far = sel & ~scl_s2 & ~scl_own;
   wire [CH-1:0] sda_far = sel & ~sda_s2 & ~sda_own;
   // the channel that started a low is kept out of its own upstream echo until both sides read high,
   // otherwise the own-drive mask hides the far low and the pair oscillates
   // limitation: a controller low overlapping that echo is not repeated onto the source channel
   wire [CH-1:0] next_scl_src = sel & (scl_far | (scl_src & ~(scl_s2 & {CH{up_s2.scl}})));
   wire [CH-1:0] next_sda_src = sel & (sda_far | (sda_src & ~(sda_s2 & {CH{up_s2.sda}})));
   wire next_scl_low = |scl_far;
   wire next_sda_low = |sda_far;

   // ==========================================
   // reset: asserted at once, released on the link clock
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) rst_sync <= 2'h0;
      else rst_sync <= {rst_sync[0], 1'b1};
   end

   // ==========================================
   // synchronisers; word is stable while request and acknowledge differ
   always_ff @(posedge i_link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         up_s1 <= 2'h3;
         up_s2 <= 2'h3;
         scl_s1 <= '1;
         scl_s2 <= '1;
         sda_s1 <= '1;
         sda_s2 <= '1;
      end else begin
         req_s1 <= i_sel_req;
         req_s2 <= req_s1;
         up_s1 <= i_up;
         up_s2 <= up_s1;
         scl_s1 <= i_dn_scl;
         scl_s2 <= scl_s1;
         sda_s1 <= i_dn_sda;
         sda_s2 <= sda_s1;
      end
   end

   // ==========================================
   // selection capture and repeated drive
   always_ff @(posedge i_link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sel <= `SW_CTRL_RESET;
         o_sel_ack <= 1'b0;
         o_dn_scl_oe <= '0;
         o_dn_sda_oe <= '0;
         scl_own1 <= '0;
         scl_own2 <= '0;
         sda_own1 <= '0;
         sda_own2 <= '0;
         scl_src <= '0;
         sda_src <= '0;
         o_dn_low <= 2'h0;
      end else begin
         if (take_word) begin
            sel <= i_sel_word;
            o_sel_ack <= req_s2;
         end
         scl_src <= next_scl_src;
         sda_src <= next_sda_src;
         o_dn_scl_oe <= sel & ~next_scl_src & {CH{~up_s2.scl}};
         o_dn_sda_oe <= sel & ~next_sda_src & {CH{~up_s2.sda}};
         scl_own1 <= o_dn_scl_oe;
         scl_own2 <= scl_own1;
         sda_own1 <= o_dn_sda_oe;
         sda_own2 <= sda_own1;
         o_dn_low <= '{scl: next_scl_low, sda: next_sda_low};
      end
   end

   // ==========================================
   // checks on the link clock
   default clocking cb @(posedge i_link_clk); endclocking
   default disable iff (!link_rst_n);

   AST_DESELECTED_NO_DRIVE: assert property ((sel == '0) |=> (o_dn_scl_oe == '0) && (o_dn_sda_oe == '0))
      else $error("unselected channel driven");
   AST_FANOUT_ALL: assert property ((!up_s2.scl && !take_word && (next_scl_src == '0)) |=> (o_dn_scl_oe == sel))
      else $error("upstream low not repeated on every selected channel");
   AST_WORD_TAKEN: assert property (take_word |=> (sel == $past(i_sel_word)) && !take_word)
      else $error("selection word not taken on request");
   COV_MULTI: cover property ((sel == 4'hf) && !up_s2.sda);

endmodule

/* i2c_ctrl_model.sv */
// upstream i2c controller model: start, stop, addressed single-byte writes and addressed single-byte reads
// assumes the bench resolves the open-drain wires with pull-ups and feeds them back on i_bus
`timescale 1ns/100ps

module i2c_ctrl_model #(
   parameter int QTR = 25
) (
   // clock
   input wire logic i_clk,
   // resolved line levels
   input wire i2c_switch_pkg::i2c_pair_type i_bus,
   // 1 = pull the line low
   output i2c_switch_pkg::i2c_pair_type o_oe
);
   import i2c_switch_pkg::*;

   // ==========================================
   // line drive
   // idle with both lines released
   initial o_oe = 2'b00;

   // set both lines just after an edge, then hold them a third of a bit
   task automatic drive(input logic scl_low, input logic sda_low);
      @(posedge i_clk);
      o_oe <= {scl_low, sda_low};
      repeat (QTR) @(posedge i_clk);
   endtask

   // ==========================================
   // bit and byte level
   // a released clock is not sampled until it is really high: a channel may stretch it
   task automatic bit_xfer(input logic b, output logic got);
      drive(1'b1, ~b);
      drive(1'b0, ~b);
      for (int k = 0; k < 1000 && i_bus.scl !== 1'b1; k++)
         @(posedge i_clk);
      got = i_bus.sda;
      drive(1'b1, ~b);
   endtask

   // eight bits msb first, then a ninth clock with data released for the acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic got;
      for (int i = 7; i >= 0; i--)
         bit_xfer(b[i], got);
      bit_xfer(1'b1, got);
      ack = ~got;
   endtask

   // start, address with write, one control byte only if the address was taken, stop
   task automatic xfer(input logic [6:0] addr, input logic [7:0] data, output logic ack_a, output logic ack_d);
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      send({addr, 1'b0}, ack_a);
      ack_d = 1'b0;
      if (ack_a)
         send(data, ack_d);
      drive(1'b1, 1'b1);
      drive(1'b0, 1'b1);
      drive(1'b0, 1'b0);
   endtask

   // start, address with read, eight data bits taken msb first, a nack, stop
   task automatic recv(input logic [6:0] addr, output logic ack_a, output logic [7:0] data);
      logic got;
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      send({addr, 1'b1}, ack_a);
      data = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, got);
         data[i] = got;
      end
      bit_xfer(1'b1, got);
      drive(1'b1, 1'b1);
      drive(1'b0, 1'b1);
      drive(1'b0, 1'b0);
   endtask
endmodule

/* quad_channel_i2c_bus_switch_test.sv */
// self-checking bench for the four-channel i2c bus switch
// assumes the design files and i2c_ctrl_model.sv are compiled before it
`timescale 1ns/100ps

module quad_channel_i2c_bus_switch_test;
   import i2c_switch_pkg::*;

   // ==========================================
   // signals
   localparam logic [6:0] ADDR = 7'h35; // arbitrary variant address, not the default
   localparam int LIMIT = 60000;
   logic i_clk = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] alert_n = 4'hf;
   logic [3:0] far_sda_low = 4'h0;
   logic [3:0] far_scl_low = 4'h0;
   logic [3:0] dn_scl, dn_sda, dn_scl_oe, dn_sda_oe, sel;
   logic alert_out_n, ack_a, ack_d;
   i2c_pair_type up_lvl, up_oe, m_oe;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   // clocks with unrelated phases
   initial forever #2 i_clk = ~i_clk;
   initial begin
      #3.3;
      forever #7.5 i_link_clk = ~i_link_clk;
   end

   // open-drain wires with pull-ups: low while any party pulls
   assign up_lvl = ~(up_oe | m_oe);
   assign dn_scl = ~(dn_scl_oe | far_scl_low);
   assign dn_sda = ~(dn_sda_oe | far_sda_low);

   // ==========================================
   // instances
   i2c_switch #(.TARGET_ADDR(ADDR), .CH(4), .POR_CYCLES(2)) i_dut (
      .i_clk(i_clk), .i_link_clk(i_link_clk), .i_rst_n(i_rst_n),
      .i_up(up_lvl), .o_up_oe(up_oe),
      .i_downstream_clock_line(dn_scl), .i_downstream_data_line(dn_sda),
      .o_downstream_clock_line_oe(dn_scl_oe), .o_downstream_data_line_oe(dn_sda_oe),
      .i_channel_alert_in_n(alert_n), .o_alert_n(alert_out_n), .o_channel_sel(sel));

   i2c_ctrl_model #(.QTR(25)) i_model (.i_clk(i_clk), .i_bus(up_lvl), .o_oe(m_oe));

   // ==========================================
   // reporting
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // a hang counts as a mismatch and still reaches the report
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         wrap_up();
      end
   end

   // ==========================================
   // scenarios
   // single channels, mixes, none, and bytes whose upper bits must be ignored
   task automatic t_select();
      logic [7:0] vals [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h05, 8'h0a, 8'hf6, 8'h9f, 8'h00};
      foreach (vals[i]) begin
         i_model.xfer(ADDR, vals[i], ack_a, ack_d);
         check({6'h0, ack_a, ack_d}, 8'h03);
         check({4'h0, sel}, {4'h0, vals[i][3:0]});
      end
   endtask

   // upstream lows reach only the selected channels, both lines
   task automatic t_follow();
      i_model.xfer(ADDR, 8'h05, ack_a, ack_d);
      i_model.drive(1'b1, 1'b0);
      check({dn_scl_oe, dn_sda_oe}, 8'h50);
      i_model.drive(1'b1, 1'b1);
      check({dn_scl_oe, dn_sda_oe}, 8'h55);
      i_model.drive(1'b0, 1'b1);
      i_model.drive(1'b0, 1'b0);
      check({dn_scl_oe, dn_sda_oe}, 8'h00);
   endtask

   // a far-side low on either line comes back upstream from a selected channel only
   task automatic t_reflect(input logic [3:0] pull, input logic exp);
      @(posedge i_clk);
      far_sda_low <= pull;
      far_scl_low <= pull;
      repeat (40) @(posedge i_clk);
      check({6'h0, up_oe.scl, up_oe.sda}, {6'h0, exp, exp});
      far_sda_low <= 4'h0;
      far_scl_low <= 4'h0;
      repeat (40) @(posedge i_clk);
      check({6'h0, up_oe.scl, up_oe.sda}, 8'h00);
   endtask

   // read-back returns the control byte with the upper bits zero
   task automatic t_read(input logic [7:0] exp);
      logic [7:0] rd;
      i_model.recv(ADDR, ack_a, rd);
      check({7'h0, ack_a}, 8'h01);
      check(rd, exp);
   endtask

   // another variant's address is refused and leaves the selection alone
   task automatic t_wrong_addr();
      i_model.xfer(7'h2a, 8'h0f, ack_a, ack_d);
      check({6'h0, ack_a, ack_d}, 8'h00);
      check({4'h0, sel}, 8'h05);
   endtask

   // every pattern of the four alerts
   task automatic t_alert();
      for (int v = 0; v < 16; v++) begin
         @(posedge i_clk);
         alert_n <= v[3:0];
         repeat (6) @(posedge i_clk);
         check({7'h0, alert_out_n}, {7'h0, &v[3:0]});
      end
      alert_n <= 4'hf;
   endtask

   // reset while all channels carry a stuck-low clock, then recovery
   task automatic t_reset();
      i_model.xfer(ADDR, 8'h0f, ack_a, ack_d);
      i_model.drive(1'b1, 1'b0);
      check({sel, dn_scl_oe}, 8'hff);
      i_rst_n <= 1'b0;
      repeat (16) @(posedge i_clk);
      check({sel, dn_scl_oe}, 8'h00);
      i_model.drive(1'b0, 1'b0);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      check({4'h0, sel}, 8'h00);
      i_model.xfer(ADDR, 8'h03, ack_a, ack_d);
      check({4'h0, sel}, 8'h03);
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      check({3'h0, sel, alert_out_n}, 8'h01);
      i_rst_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      t_select();
      t_follow();
      t_read(8'h05);
      t_reflect(4'h1, 1'b1);
      t_reflect(4'h2, 1'b0);
      t_wrong_addr();
      t_alert();
      t_reset();
      wrap_up();
   end
endmodule
